// ===== asp_dev_end.sv
`timescale 1ns/1ps
// Functional notes
// - words are two's complement, msb first
// - left word precedes right word each frame
// - up to 24 bits; extra bits dropped silently
// - right-justified length 16/20/24, reset 24
// - source gives 64 bit clocks per frame
// - mode bits in control register pick framing
// - left-justified: frame high left, msb at edge
// - i2s: frame low left, msb one bit late
// - right-justified: data starts 16/12/8 bits late
// - dsp: frame pulse precedes each msb
// - dsp: sample on falling bit clock edge
// - dsp: source sends left word first
// - frame at fs (2fs dsp), 64 bits
// - capture frame low 128, high 128 bits
// - 32-bit slots, msb one bit late
// - mute pin mutes left, right, sub
// - mute control bit mutes as alternative
// - gain ramps; unmute returns to volume
module asp_dev_end #(
	parameter logic [15:0] RAMP_STEP = asp_pkg::RAMP_STEP_DEF
) (
	asp_link_if.dev                          link,
	input  wire logic                        clk,
	input  wire logic                        nrst,
	input  wire logic [asp_pkg::REG_AW-1:0]  addr,
	input  wire logic [31:0]                 wdata,
	input  wire logic                        wr,
	input  wire logic                        rd,
	output logic      [31:0]                 rdata,
	output logic      [asp_pkg::WORD_W-1:0]  sample_l,
	output logic      [asp_pkg::WORD_W-1:0]  sample_r,
	output logic                             sample_valid,
	output logic                             muted
);
	import asp_pkg::*;
	if (RAMP_STEP == 16'h0000) begin : g_chk
		$error("RAMP_STEP must be nonzero");
	end

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic [31:0]        ctrl;
		logic [GAIN_W-1:0]  vol;
		logic               cfg_tgl;
		logic [2:0]         frm_s;
		logic [2:0]         st_s1;
		logic [2:0]         st_s2;
		logic [WORD_W-1:0]  l;
		logic [WORD_W-1:0]  r;
		logic               valid;
		logic [31:0]        rdata;
	} asp_sys_t;

	typedef struct packed {
		logic [1:0]                     cfg_s;
		logic                           cfg_prev;
		logic [1:0]                     mode;
		logic [1:0]                     wl;
		logic                           mute_bit;
		logic [GAIN_W-1:0]              vol;
		logic [1:0]                     mpin_s;
		logic                           lr_q;
		logic [5:0]                     cnt;
		logic [WORD_W-1:0]              sh;
		logic                           cur_left;
		logic                           got_l;
		logic [WORD_W-1:0]              stg_l;
		logic [WORD_W-1:0]              out_l;
		logic [WORD_W-1:0]              out_r;
		logic                           frm_tgl;
		logic [GAIN_W-1:0]              gain;
		logic [2:0]                     st;
		logic [7:0]                     tc;
		logic [TDM_CH-1:0][WORD_W-1:0]  slot;
	} asp_lnk_t;

	typedef struct packed {
		logic n_lr;
		logic n_sd;
		logic fs;
		logic sd;
	} asp_neg_t;

	asp_sys_t   sy;
	asp_sys_t   next_sy;
	asp_lnk_t   ln;
	asp_lnk_t   next_ln;
	asp_neg_t   ng;
	logic [1:0] lrst_s;
	logic       lrst_n;
	logic       next_tdm_fs;
	logic       next_tdm_sd;

	function automatic logic [WORD_W-1:0] asp_scale(input logic [WORD_W-1:0] w, input logic [GAIN_W-1:0] g);
		logic signed [40:0] p;
		p = $signed(w) * $signed({1'b0, g});
		return p[38:15];
	endfunction

	// ----------------------------------------
	// register port, clk domain
	// ----------------------------------------
	always_comb begin
		next_sy       = sy;
		next_sy.valid = 1'b0;
		next_sy.rdata = 32'h0000_0000;
		if (wr && addr == REG_CTRL) begin
			next_sy.ctrl    = wdata & CTRL_MASK;
			next_sy.cfg_tgl = ~sy.cfg_tgl;
		end
		if (wr && addr == REG_VOL) begin
			next_sy.vol     = wdata[GAIN_W-1:0];
			next_sy.cfg_tgl = ~sy.cfg_tgl;
		end
		if (rd) begin
			case (addr)
				REG_CTRL:  next_sy.rdata = sy.ctrl;
				REG_VOL:   next_sy.rdata = {16'h0000, sy.vol};
				REG_STAT:  next_sy.rdata = {29'h0000_0000, sy.st_s2};
				REG_LEFT:  next_sy.rdata = {8'h00, sy.l};
				REG_RIGHT: next_sy.rdata = {8'h00, sy.r};
				default:   next_sy.rdata = 32'h0000_0000;
			endcase
		end
		// frame words cross on a toggle; the words hold for a whole frame
		next_sy.frm_s = {sy.frm_s[1:0], ln.frm_tgl};
		next_sy.st_s1 = ln.st;
		next_sy.st_s2 = sy.st_s1;
		if (sy.frm_s[2] != sy.frm_s[1]) begin
			next_sy.l     = ln.out_l;
			next_sy.r     = ln.out_r;
			next_sy.valid = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst)
			sy <= '{ctrl: CTRL_RST, vol: VOL_RST, default: '0};
		else
			sy <= next_sy;
	end

	assign rdata        = sy.rdata;
	assign sample_l     = sy.l;
	assign sample_r     = sy.r;
	assign sample_valid = sy.valid;
	assign muted        = sy.st_s2[STAT_MUTED_BIT];

	// ----------------------------------------
	// link reset, async assert, bclk release
	// ----------------------------------------
	always_ff @(posedge link.bclk or negedge nrst) begin
		if (!nrst)
			lrst_s <= 2'h0;
		else
			lrst_s <= {lrst_s[0], 1'b1};
	end
	assign lrst_n = lrst_s[1];

	// ----------------------------------------
	// serial receiver, gain ramp, capture output
	// ----------------------------------------
	always_comb begin
		logic              dsp;
		logic              s_lr;
		logic              s_sd;
		logic              edg;
		logic              mute;
		logic [5:0]        start;
		logic [5:0]        pos;
		logic [5:0]        k;
		logic [GAIN_W-1:0] target;
		logic [WORD_W-1:0] gl;
		logic [WORD_W-1:0] gr;
		logic [WORD_W:0]   sum;
		logic [2:0]        sl;
		logic [2:0]        ch;
		logic [4:0]        bp;
		dsp    = ln.mode == ASP_DSP;
		s_lr   = dsp ? ng.n_lr : link.lrclk;
		s_sd   = dsp ? ng.n_sd : link.sdata;
		edg    = dsp ? (ln.lr_q & ~s_lr) : (ln.lr_q ^ s_lr);
		mute   = ln.mute_bit | ln.mpin_s[1];
		start  = LJ_START;
		target = mute ? '0 : ((ln.vol > GAIN_UNITY) ? GAIN_UNITY : ln.vol);
		gl     = asp_scale(ln.out_l, ln.gain);
		gr     = asp_scale(ln.out_r, ln.gain);
		sum    = {gl[WORD_W-1], gl} + {gr[WORD_W-1], gr};
		sl     = ln.tc[7:5];
		bp     = ln.tc[4:0];
		ch     = (sl < TDM_GAP_LO) ? sl : sl - 3'h1;
		next_ln = ln;
		case (ln.mode)
			ASP_I2S: start = I2S_START;
			ASP_RJ:  start = (ln.wl == ASP_WL16) ? RJ_START16 : (ln.wl == ASP_WL20) ? RJ_START20 : RJ_START24;
			default: start = LJ_START;
		endcase
		pos = edg ? 6'h00 : ((ln.cnt == POS_LAST) ? ln.cnt : ln.cnt + 6'h01);
		k   = pos - start;
		next_ln.lr_q = s_lr;
		next_ln.cnt  = pos;
		if (edg)
			next_ln.sh = '0;
		if (pos >= start && k < WL_BITS24 && !(dsp && s_lr))
			next_ln.sh[5'(WORD_W - 1) - k[4:0]] = s_sd;
		if (edg) begin
			next_ln.cur_left = dsp ? ~ln.cur_left : ((ln.mode == ASP_I2S) ? ~s_lr : s_lr);
			if (ln.cur_left) begin
				next_ln.stg_l = ln.sh;
				next_ln.got_l = 1'b1;
			end else if (ln.got_l) begin
				next_ln.out_l   = ln.stg_l;
				next_ln.out_r   = ln.sh;
				next_ln.frm_tgl = ~ln.frm_tgl;
				next_ln.got_l   = 1'b0;
				// one gain step per frame
				if (ln.gain < target)
					next_ln.gain = (target - ln.gain > RAMP_STEP) ? ln.gain + RAMP_STEP : target;
				else if (ln.gain > target)
					next_ln.gain = (ln.gain - target > RAMP_STEP) ? ln.gain - RAMP_STEP : target;
			end
		end
		next_ln.cfg_s  = {ln.cfg_s[0], sy.cfg_tgl};
		next_ln.mpin_s = {ln.mpin_s[0], link.mute};
		next_ln.cfg_prev = ln.cfg_s[1];
		if (ln.cfg_s[1] != ln.cfg_prev) begin
			next_ln.mode     = sy.ctrl[CTRL_MODE_LSB +: 2];
			next_ln.wl       = sy.ctrl[CTRL_WL_LSB +: 2];
			next_ln.mute_bit = sy.ctrl[CTRL_MUTE_BIT];
			next_ln.vol      = sy.vol;
			next_ln.got_l    = 1'b0;
			next_ln.cur_left = 1'b0;
		end
		next_ln.st[STAT_MUTED_BIT]  = ln.gain == '0;
		next_ln.st[STAT_AT_VOL_BIT] = ln.gain == target;
		next_ln.st[STAT_PIN_BIT]    = ln.mpin_s[1];
		next_ln.tc = ln.tc + 8'h01;
		if (ln.tc == TDM_LAST) begin
			next_ln.slot[0] = ln.out_l;
			next_ln.slot[1] = ln.out_r;
			next_ln.slot[2] = gl;
			next_ln.slot[3] = gr;
			next_ln.slot[4] = sum[WORD_W:1];
			next_ln.slot[5] = '0;
		end
		next_tdm_fs = ln.tc[TDM_FS_BIT];
		next_tdm_sd = 1'b0;
		if (sl != TDM_GAP_LO && sl != TDM_GAP_HI && bp >= TDM_MSB_POS && bp <= TDM_LSB_POS)
			next_tdm_sd = ln.slot[ch][5'(WORD_W) - bp];
	end

	always_ff @(posedge link.bclk or negedge lrst_n) begin
		if (!lrst_n) begin
			ln     <= '0;
			ln.wl  <= ASP_WL24;
			ln.vol <= VOL_RST;
		end else begin
			ln <= next_ln;
		end
	end

	// dsp input sampling and capture output drive on the falling edge
	always_ff @(negedge link.bclk or negedge lrst_n) begin
		if (!lrst_n) begin
			ng <= '0;
		end else begin
			ng.n_lr <= link.lrclk;
			ng.n_sd <= link.sdata;
			ng.fs   <= next_tdm_fs;
			ng.sd   <= next_tdm_sd;
		end
	end

	assign link.tdm_fs = ng.fs;
	assign link.tdm_sd = ng.sd;

endmodule

// ===== asp_pkg.sv
package asp_pkg;

	// ----------------------------------------
	// widths and sizes
	// ----------------------------------------
	localparam int WORD_W = 24;
	localparam int REG_AW = 5;
	localparam int GAIN_W = 16;
	localparam int TDM_CH = 6;

	// ----------------------------------------
	// framing modes and word lengths
	// ----------------------------------------
	typedef enum logic [1:0] {
		ASP_LJ  = 2'h0,
		ASP_I2S = 2'h1,
		ASP_RJ  = 2'h2,
		ASP_DSP = 2'h3
	} asp_mode_t;

	localparam logic [1:0] ASP_WL16 = 2'h0;
	localparam logic [1:0] ASP_WL20 = 2'h1;
	localparam logic [1:0] ASP_WL24 = 2'h2;

	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [REG_AW-1:0] REG_CTRL  = 5'h00;
	localparam logic [REG_AW-1:0] REG_VOL   = 5'h04;
	localparam logic [REG_AW-1:0] REG_STAT  = 5'h08;
	localparam logic [REG_AW-1:0] REG_LEFT  = 5'h0C;
	localparam logic [REG_AW-1:0] REG_RIGHT = 5'h10;

	localparam int CTRL_WL_LSB     = 0;
	localparam int CTRL_MODE_LSB   = 2;
	localparam int CTRL_MUTE_BIT   = 4;
	localparam int STAT_MUTED_BIT  = 0;
	localparam int STAT_AT_VOL_BIT = 1;
	localparam int STAT_PIN_BIT    = 2;

	localparam logic [31:0]       CTRL_MASK     = 32'h0000_001F;
	localparam logic [31:0]       CTRL_RST      = 32'h0000_0002;
	localparam logic [GAIN_W-1:0] VOL_RST       = 16'h8000;
	localparam logic [GAIN_W-1:0] GAIN_UNITY    = 16'h8000;
	localparam logic [GAIN_W-1:0] RAMP_STEP_DEF = 16'h0100;

	// ----------------------------------------
	// serial input timing, in bit clocks
	// ----------------------------------------
	localparam logic [5:0] POS_LAST   = 6'h3F;
	localparam logic [4:0] PULSE_POS  = 5'h1F;
	localparam logic [5:0] LJ_START   = 6'h00;
	localparam logic [5:0] I2S_START  = 6'h01;
	localparam logic [5:0] RJ_START16 = 6'h10;
	localparam logic [5:0] RJ_START20 = 6'h0C;
	localparam logic [5:0] RJ_START24 = 6'h08;
	localparam logic [5:0] WL_BITS16  = 6'h10;
	localparam logic [5:0] WL_BITS20  = 6'h14;
	localparam logic [5:0] WL_BITS24  = 6'h18;

	// ----------------------------------------
	// capture output timing, in bit clocks
	// ----------------------------------------
	localparam logic [7:0] TDM_LAST    = 8'hFF;
	localparam int         TDM_FS_BIT  = 7;
	localparam logic [4:0] TDM_MSB_POS = 5'h01;
	localparam logic [4:0] TDM_LSB_POS = 5'h18;
	localparam logic [2:0] TDM_GAP_LO  = 3'h3;
	localparam logic [2:0] TDM_GAP_HI  = 3'h7;

endpackage

// ===== asp_link_if.sv
`timescale 1ns/1ps
interface asp_link_if;
	logic bclk;
	logic lrclk;
	logic sdata;
	logic mute;
	logic tdm_fs;
	logic tdm_sd;

	modport dev (
		input  bclk,
		input  lrclk,
		input  sdata,
		input  mute,
		output tdm_fs,
		output tdm_sd
	);

	modport src (
		output bclk,
		output lrclk,
		output sdata,
		output mute,
		input  tdm_fs,
		input  tdm_sd
	);
endinterface

// ===== asp_src_end.sv
`timescale 1ns/1ps
module asp_src_end #(
	parameter int HALF = 4
) (
	asp_link_if.src                          link,
	input  wire logic                        clk,
	input  wire logic                        nrst,
	input  wire asp_pkg::asp_mode_t          mode,
	input  wire logic [1:0]                  wlen,
	input  wire logic [asp_pkg::WORD_W-1:0]  tx_l,
	input  wire logic [asp_pkg::WORD_W-1:0]  tx_r,
	input  wire logic                        tx_valid,
	output logic                             tx_ready,
	input  wire logic                        mute_in,
	output logic      [asp_pkg::WORD_W-1:0]  rx_word,
	output logic      [2:0]                  rx_ch,
	output logic                             rx_valid
);
	import asp_pkg::*;

	if (HALF < 3 || HALF > 255) begin : g_chk
		$error("HALF must be 3 to 255");
	end

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic [7:0]        dcnt;
		logic              bclk;
		logic [5:0]        bc;
		logic              lr;
		logic              sd;
		logic              mute;
		logic [WORD_W-1:0] cur_l;
		logic [WORD_W-1:0] cur_r;
		logic [1:0]        fs_s;
		logic [1:0]        sd_s;
		logic              fs_prev;
		logic              locked;
		logic              dsp_arm;
		logic              dsp_go;
		logic [7:0]        rtc;
		logic [WORD_W-1:0] sh;
		logic [WORD_W-1:0] rx_word;
		logic [2:0]        rx_ch;
		logic              rx_valid;
	} asp_src_t;

	asp_src_t st;
	asp_src_t next_st;

	// ----------------------------------------
	// bit clock divider, serializer, capture receiver
	// ----------------------------------------
	always_comb begin
		logic              tick;
		logic              rise;
		logic              drive;
		logic              left;
		logic [4:0]        p;
		logic [5:0]        start;
		logic [5:0]        wl;
		logic [5:0]        k;
		logic [WORD_W-1:0] word;
		logic [7:0]        rtc_n;
		logic [4:0]        bp;
		logic [2:0]        sl;
		tick  = st.dcnt == 8'(HALF - 1);
		rise  = tick & ~st.bclk;
		drive = (mode == ASP_DSP) ? rise : (tick & st.bclk);
		left  = ~st.bc[5];
		p     = st.bc[4:0];
		start = LJ_START;
		wl    = WL_BITS24;
		rtc_n = st.rtc;
		bp    = st.rtc[4:0];
		sl    = st.rtc[7:5];
		next_st = st;
		next_st.rx_valid = 1'b0;
		next_st.dcnt = tick ? 8'h00 : st.dcnt + 8'h01;
		if (tick)
			next_st.bclk = ~st.bclk;
		case (mode)
			ASP_I2S: start = I2S_START;
			ASP_RJ: begin
				start = (wlen == ASP_WL16) ? RJ_START16 : (wlen == ASP_WL20) ? RJ_START20 : RJ_START24;
				wl    = (wlen == ASP_WL16) ? WL_BITS16 : (wlen == ASP_WL20) ? WL_BITS20 : WL_BITS24;
			end
			default: start = LJ_START;
		endcase
		k        = {1'b0, p} - start;
		word     = left ? st.cur_l : st.cur_r;
		tx_ready = drive && st.bc == POS_LAST;
		if (drive) begin
			unique case (mode)
				ASP_LJ:  next_st.lr = left;
				ASP_I2S: next_st.lr = ~left;
				ASP_RJ:  next_st.lr = left;
				ASP_DSP: next_st.lr = p == PULSE_POS && (st.dsp_go || (st.dsp_arm && st.bc == POS_LAST));
			endcase
			next_st.sd = ({1'b0, p} >= start && k < wl) ? word[5'(WORD_W - 1) - k[4:0]] : 1'b0;
			next_st.bc = st.bc + 6'h01;
			if (st.bc == '0)
				next_st.dsp_arm = 1'b1;
			if (st.dsp_arm && st.bc == POS_LAST)
				next_st.dsp_go = 1'b1;
			if (tx_ready && tx_valid) begin
				next_st.cur_l = tx_l;
				next_st.cur_r = tx_r;
			end
		end
		// pulses held off for a whole count, so the first one marks a left word
		if (mode != ASP_DSP) begin
			next_st.dsp_arm = 1'b0;
			next_st.dsp_go  = 1'b0;
		end
		next_st.mute = mute_in;
		next_st.fs_s = {st.fs_s[0], link.tdm_fs};
		next_st.sd_s = {st.sd_s[0], link.tdm_sd};
		if (rise) begin
			rtc_n = (st.fs_prev & ~st.fs_s[1]) ? 8'h00 : st.rtc + 8'h01;
			bp    = rtc_n[4:0];
			sl    = rtc_n[7:5];
			next_st.rtc     = rtc_n;
			next_st.fs_prev = st.fs_s[1];
			if (st.fs_prev & ~st.fs_s[1])
				next_st.locked = 1'b1;
			if (bp >= TDM_MSB_POS && bp <= TDM_LSB_POS)
				next_st.sh[5'(WORD_W) - bp] = st.sd_s[1];
			if (bp == TDM_LSB_POS && st.locked && sl != TDM_GAP_LO && sl != TDM_GAP_HI) begin
				next_st.rx_word  = next_st.sh;
				next_st.rx_ch    = (sl < TDM_GAP_LO) ? sl : sl - 3'h1;
				next_st.rx_valid = 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst)
			st <= '0;
		else
			st <= next_st;
	end

	assign link.bclk  = st.bclk;
	assign link.lrclk = st.lr;
	assign link.sdata = st.sd;
	assign link.mute  = st.mute;
	assign rx_word    = st.rx_word;
	assign rx_ch      = st.rx_ch;
	assign rx_valid   = st.rx_valid;

endmodule

// ===== asp_properties.sv
`timescale 1ns/1ps
module asp_properties (
	input wire logic               bclk,
	input wire logic               lrclk,
	input wire logic               sdata,
	input wire logic               mute,
	input wire logic               tdm_fs,
	input wire logic               tdm_sd,
	input wire logic               nrst,
	input wire asp_pkg::asp_mode_t mode
);
	import asp_pkg::*;
	// ----------------------------------------
	// bit counters since last frame edges
	// ----------------------------------------
	logic [8:0] fs_cnt;
	logic       fs_seen;
	logic       fs_q;
	logic [6:0] lr_cnt;
	logic [1:0] lr_seen;
	logic       lr_q;
	asp_mode_t  mode_q;
	logic [5:0] dp_cnt;
	logic [1:0] dp_seen;
	logic       lr_nq;

	always_ff @(posedge bclk or negedge nrst) begin
		if (!nrst) begin
			fs_cnt  <= 9'h000;
			fs_seen <= 1'b0;
			fs_q    <= 1'b0;
			lr_cnt  <= 7'h00;
			lr_seen <= 2'h0;
			lr_q    <= 1'b0;
			mode_q  <= ASP_LJ;
		end else begin
			fs_q   <= tdm_fs;
			lr_q   <= lrclk;
			mode_q <= mode;
			fs_cnt <= (fs_q && !tdm_fs) ? 9'h001 : fs_cnt + 9'h001;
			if (fs_q && !tdm_fs) fs_seen <= 1'b1;
			lr_cnt <= (!lr_q && lrclk) ? 7'h01 : lr_cnt + 7'h01;
			// two rises after a mode change before frame length is trusted
			if (mode != mode_q) lr_seen <= 2'h0;
			else if (!lr_q && lrclk && !lr_seen[1]) lr_seen <= lr_seen + 2'h1;
		end
	end

	always_ff @(negedge bclk or negedge nrst) begin
		if (!nrst) begin
			dp_cnt  <= 6'h00;
			dp_seen <= 2'h0;
			lr_nq   <= 1'b0;
		end else begin
			lr_nq  <= lrclk;
			dp_cnt <= (!lr_nq && lrclk) ? 6'h01 : dp_cnt + 6'h01;
			if (mode != ASP_DSP) dp_seen <= 2'h0;
			else if (!lr_nq && lrclk && !dp_seen[1]) dp_seen <= dp_seen + 2'h1;
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	a_tdm_fs_rise: assert property (@(posedge bclk) disable iff (!nrst)
		fs_seen && !fs_q && tdm_fs |-> fs_cnt == 9'd128) else $error("capture frame clock rose off count 128");
	a_tdm_fs_fall: assert property (@(posedge bclk) disable iff (!nrst)
		fs_seen && $fell(tdm_fs) |-> fs_cnt == 9'd256) else $error("capture frame not 256 bit clocks");
	a_tdm_slot_pad: assert property (@(posedge bclk) disable iff (!nrst)
		fs_seen && (fs_cnt[4:0] == 5'd0 || fs_cnt[4:0] > 5'd24) |-> !tdm_sd) else $error("slot padding not zero");
	a_tdm_idle_slot: assert property (@(posedge bclk) disable iff (!nrst)
		fs_seen && fs_cnt[7:5] == 3'd3 |-> !tdm_sd) else $error("idle capture slot not zero");
	a_lr_frame_len: assert property (@(posedge bclk) disable iff (!nrst)
		mode != ASP_DSP && mode == mode_q && lr_seen[1] && $rose(lrclk) |-> lr_cnt == 7'd64) else $error("frame not 64 bit clocks");
	a_lr_half_len: assert property (@(posedge bclk) disable iff (!nrst)
		mode != ASP_DSP && mode == mode_q && lr_seen[1] && $fell(lrclk) |-> lr_cnt == 7'd32) else $error("channel half not 32 bits");
	a_dsp_pulse_width: assert property (@(negedge bclk) disable iff (!nrst)
		mode == ASP_DSP && dp_seen[1] && !lr_nq && lrclk |=> !lrclk) else $error("frame pulse not one bit wide");
	a_dsp_pulse_gap: assert property (@(negedge bclk) disable iff (!nrst)
		mode == ASP_DSP && dp_seen[1] && $rose(lrclk) |-> dp_cnt == 6'd32) else $error("frame pulses not 32 apart");
endmodule

// ===== testbench.sv
`timescale 1ns/1ps
module testbench;
	import asp_pkg::*;
	logic              clk;
	logic              nrst;
	logic [REG_AW-1:0] addr;
	logic [31:0]       wdata;
	logic              wr;
	logic              rd;
	logic [31:0]       rdata;
	logic [WORD_W-1:0] sample_l;
	logic [WORD_W-1:0] sample_r;
	logic              sample_valid;
	logic              muted;
	asp_mode_t         mode;
	logic [1:0]        wlen;
	logic [WORD_W-1:0] tx_l;
	logic [WORD_W-1:0] tx_r;
	logic              tx_valid;
	logic              tx_ready;
	logic              mute_in;
	logic [WORD_W-1:0] rx_word;
	logic [2:0]        rx_ch;
	logic              rx_valid;
	int                failures;
	int                samples_checked;
	logic [31:0]       rv;
	logic [WORD_W-1:0] w;

	asp_link_if u_asp_link_if();
	asp_dev_end #(.RAMP_STEP(16'h2000)) u_asp_dev_end (.link(u_asp_link_if.dev), .clk(clk), .nrst(nrst),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .sample_l(sample_l),
		.sample_r(sample_r), .sample_valid(sample_valid), .muted(muted));
	asp_src_end #(.HALF(4)) u_asp_src_end (.link(u_asp_link_if.src), .clk(clk), .nrst(nrst), .mode(mode),
		.wlen(wlen), .tx_l(tx_l), .tx_r(tx_r), .tx_valid(tx_valid), .tx_ready(tx_ready), .mute_in(mute_in),
		.rx_word(rx_word), .rx_ch(rx_ch), .rx_valid(rx_valid));
	asp_properties u_asp_properties (.bclk(u_asp_link_if.bclk), .lrclk(u_asp_link_if.lrclk),
		.sdata(u_asp_link_if.sdata), .mute(u_asp_link_if.mute), .tdm_fs(u_asp_link_if.tdm_fs),
		.tdm_sd(u_asp_link_if.tdm_sd), .nrst(nrst), .mode(mode));

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic hung(input string name);
		failures++;
		$display("[ERR] %s expected event seen timeout", name);
		summarize();
	endtask

	task automatic wr_reg(input logic [REG_AW-1:0] a, input logic [31:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr    <= 1'b0;
	endtask

	task automatic rd_reg(input logic [REG_AW-1:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd   <= 1'b0;
		#1;
		d = rdata;
	endtask

	// waits for n published frames
	task automatic frames(input int n);
		int got;
		got = 0;
		for (int i = 0; i < 4000 * n && got < n; i++) begin
			@(posedge clk);
			#1;
			if (sample_valid === 1'b1) got++;
		end
		if (got < n) hung("sample_valid");
	endtask

	task automatic get_ch(input logic [2:0] c, output logic [WORD_W-1:0] d);
		int i;
		for (i = 0; i < 6000; i++) begin
			@(posedge clk);
			#1;
			if (rx_valid === 1'b1 && rx_ch === c) break;
		end
		if (i == 6000) hung("rx_valid");
		d = rx_word;
	endtask

	// frame load strobe spacing: 64 bit clocks of 8 clk each
	task automatic rdy_gap();
		int n;
		int gap;
		n   = 0;
		gap = 0;
		for (int i = 0; i < 2000 && n < 2; i++) begin
			@(posedge clk);
			#1;
			if (n == 1) gap++;
			if (tx_ready === 1'b1) n++;
		end
		if (n < 2) hung("tx_ready");
		check("tx_ready_gap", 32'(gap), 32'h0000_0200);
	endtask

	task automatic set_cfg(input asp_mode_t m, input logic [1:0] wl, input logic mb);
		@(posedge clk);
		mode <= m;
		wlen <= wl;
		wr_reg(REG_CTRL, {27'h0, mb, m, wl});
		frames(4);
	endtask

	task automatic data_test(input asp_mode_t m, input logic [1:0] wl, input logic [23:0] keep);
		set_cfg(m, wl, 1'b0);
		check("sample_l", 32'(sample_l), 32'(tx_l & keep));
		check("sample_r", 32'(sample_r), 32'(tx_r & keep));
		rd_reg(REG_LEFT, rv);
		check("left_reg", rv, 32'(tx_l & keep));
		rd_reg(REG_RIGHT, rv);
		check("right_reg", rv, 32'(tx_r & keep));
		$display("test mode %0d wlen %0d done", m, wl);
	endtask

	// ----------------------------------------
	// clock, reset and sequence
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	initial begin
		nrst = 1'b0; addr = '0; wdata = '0; wr = 1'b0; rd = 1'b0;
		mode = ASP_LJ; wlen = ASP_WL24; tx_l = 24'hA5_3C96; tx_r = 24'h3E_71C8;
		tx_valid = 1'b1; mute_in = 1'b0; failures = 0; samples_checked = 0;
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		wr_reg(5'h14, 32'hFFFF_FFFF);
		rd_reg(REG_CTRL, rv);
		check("ctrl_reset", rv, CTRL_RST);
		rd_reg(REG_VOL, rv);
		check("vol_reset", rv, 32'(VOL_RST));
		rd_reg(5'h14, rv);
		check("unmapped", rv, 32'h0000_0000);
		$display("test reset done");
		data_test(ASP_LJ, ASP_WL24, 24'hFF_FFFF);
		data_test(ASP_I2S, ASP_WL24, 24'hFF_FFFF);
		data_test(ASP_DSP, ASP_WL24, 24'hFF_FFFF);
		for (int k = 0; k < 3; k++) begin
			data_test(ASP_RJ, 2'(k), 24'hFF_FFFF << (8 - 4 * k));
		end
		rdy_gap();
		frames(2);
		rd_reg(REG_STAT, rv);
		check("stat_unity", rv, 32'h0000_0002);
		get_ch(3'd2, w);
		check("ch2_unity", 32'(w), 32'(tx_l));
		mute_in <= 1'b1;
		frames(1);
		check("muted_ramp", 32'(muted), 32'h0000_0000);
		frames(6);
		check("muted_pin", 32'(muted), 32'h0000_0001);
		rd_reg(REG_STAT, rv);
		check("stat_pin", rv, 32'h0000_0007);
		get_ch(3'd0, w);
		check("ch0_raw", 32'(w), 32'(tx_l));
		get_ch(3'd1, w);
		check("ch1_raw", 32'(w), 32'(tx_r));
		get_ch(3'd2, w);
		check("ch2_muted", 32'(w), 32'h0000_0000);
		get_ch(3'd4, w);
		check("ch4_muted", 32'(w), 32'h0000_0000);
		get_ch(3'd5, w);
		check("ch5_zero", 32'(w), 32'h0000_0000);
		$display("test mute pin done");
		mute_in <= 1'b0;
		set_cfg(ASP_RJ, ASP_WL24, 1'b1);
		frames(2);
		check("muted_bit", 32'(muted), 32'h0000_0001);
		rd_reg(REG_STAT, rv);
		check("stat_bit", rv, 32'h0000_0003);
		wr_reg(REG_VOL, 32'h0000_4000);
		frames(1);
		set_cfg(ASP_RJ, ASP_WL24, 1'b0);
		frames(2);
		check("unmuted", 32'(muted), 32'h0000_0000);
		rd_reg(REG_STAT, rv);
		check("stat_vol", rv, 32'h0000_0002);
		get_ch(3'd2, w);
		check("ch2_half", 32'(w), 32'h00D2_9E4B);
		get_ch(3'd3, w);
		check("ch3_half", 32'(w), 32'h001F_38E4);
		$display("test mute bit and volume done");
		summarize();
	end
endmodule
